// ==== src/lmac_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmac_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [lmac_pkg::RA-1:0] reg_addr,
  input wire logic [lmac_pkg::RD-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lmac_pkg::RD-1:0] reg_rdata,
  // pixel input stream
  input wire logic pixel_in_valid,
  output logic pixel_in_ready,
  input wire logic [lmac_pkg::DW-1:0] pixel_in_bus,
  input wire logic array_hold,
  // cascade input
  input wire logic [lmac_pkg::AW-1:0] cascade_in_bus,
  // outputs
  output logic [lmac_pkg::DW-1:0] pixel_out_bus,
  output logic [lmac_pkg::AW-1:0] cascade_out_bus,
  output logic sample_step
);
  import lmac_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] system_control_reg_r;
  logic [2:0] array_control_reg_r;
  logic [DLW-1:0] len_r [0:FILT-1];
  logic [CW-1:0] coef_r [0:1][0:NCOEF-1];
  logic bank_r;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_full_r;
  logic [DW-1:0] fifo_data;
  logic adv;
  logic [DW-1:0] px_r;
  logic [DW-1:0] tap [0:FILT];
  logic [DW-1:0] pix_pad_r [0:PIX_PAD-1];
  logic signed [AW-1:0] acc_r [0:FILT-1][0:TAPS-1];
  logic signed [AW-1:0] link_r [0:FILT-2];
  logic signed [AW-1:0] mac_pad_r [0:MAC_PAD-1];
  logic signed [AW-1:0] cin_pad_r [0:CIN_PAD-1];
  logic data_sgn;
  logic coef_sgn;
  logic coef_wr;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // one full precision product, widened to the accumulator
  function automatic logic signed [AW-1:0] mac_term(
    input logic [DW-1:0] d,
    input logic [CW-1:0] c,
    input logic ds,
    input logic cs
  );
    logic signed [DW:0] a;
    logic signed [CW:0] b;
    logic signed [DW+CW+1:0] p;
    a = signed'({ds & d[DW-1], d});
    b = signed'({cs & c[CW-1], c});
    p = a * b;
    mac_term = AW'(p);
  endfunction

  // coefficient area decode
  function automatic logic coef_hit(input logic [RA-1:0] a);
    coef_hit = (a[RA-1:COEF_BANK_BIT+1] == COEF_AREA) && (a[4:0] < 5'(NCOEF));
  endfunction

  assign data_sgn = array_control_reg_r[ARR_DSGN_BIT];
  assign coef_sgn = array_control_reg_r[ARR_CSGN_BIT];
  assign coef_wr = reg_wr && coef_hit(reg_addr);

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  // the array advances one sample per step; hold stalls the drain
  assign adv = fifo_valid & ~array_hold;
  assign fifo_ready = ~array_hold;

  lmac_fifo #(
    .W(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(pixel_in_valid),
    .in_ready(pixel_in_ready),
    .in_data(pixel_in_bus),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // full flag mirror for status
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fifo_full_r <= 1'b0;
    end else begin
      fifo_full_r <= fifo_valid & ~pixel_in_ready; // ready is low out of reset, fifo empty
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // system control: swap mode and bypass
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      system_control_reg_r <= SYS_RST;
    end else if (reg_wr && reg_addr == REG_SYS) begin
      system_control_reg_r <= reg_wdata[1:0];
    end
  end

  // array control: bank select and number formats
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      array_control_reg_r <= ARR_RST;
    end else if (reg_wr && reg_addr == REG_ARR) begin
      array_control_reg_r <= reg_wdata[2:0];
    end
  end

  // delay lengths, one register per line
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int f = 0; f < FILT; f++) begin
        len_r[f] <= LEN_RST;
      end
    end else begin
      for (int f = 0; f < FILT; f++) begin
        if (reg_wr && reg_addr == RA'(REG_LEN0 + RA'(f))) begin
          len_r[f] <= reg_wdata[DLW-1:0];
        end
      end
    end
  end

  // coefficient banks, writable at any time
  always_ff @(posedge sys_clk) begin
    if (coef_wr) begin
      coef_r[reg_addr[COEF_BANK_BIT]][reg_addr[4:0]] <= reg_wdata[CW-1:0];
    end
  end

  // active bank: written select wins, else toggles per step in swap mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bank_r <= ARR_RST[ARR_BANK_BIT];
    end else if (reg_wr && reg_addr == REG_ARR) begin
      bank_r <= reg_wdata[ARR_BANK_BIT];
    end else if (adv && system_control_reg_r[SYS_SWAP_BIT]) begin
      bank_r <= ~bank_r;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        if (reg_addr == REG_SYS) begin
          reg_rdata <= RD'(system_control_reg_r);
        end else if (reg_addr == REG_ARR) begin
          reg_rdata <= RD'(array_control_reg_r);
        end else if (reg_addr == REG_STAT) begin
          reg_rdata[STAT_BANK_BIT] <= bank_r;
          reg_rdata[STAT_EMPTY_BIT] <= ~fifo_valid;
          reg_rdata[STAT_FULL_BIT] <= fifo_full_r;
        end else if (coef_hit(reg_addr)) begin
          reg_rdata <= RD'(coef_r[reg_addr[COEF_BANK_BIT]][reg_addr[4:0]]);
        end else begin
          for (int f = 0; f < FILT; f++) begin
            if (reg_addr == RA'(REG_LEN0 + RA'(f))) begin
              reg_rdata <= RD'(len_r[f]);
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // programmable delay lines
  // ----------------------------------------------------------------
  assign tap[0] = px_r;

  // lines in series, each output also taps a filter
  for (genvar g = 0; g < FILT; g++) begin : g_line
    lmac_delay #(
      .W(DW),
      .DEPTH(DL_MAX),
      .LW(DLW)
    ) u_line (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .en(adv),
      .len(len_r[g]),
      .din(tap[g]),
      .dout(tap[g+1])
    );
  end

  // input register and pixel output chain
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      px_r <= '0;
      pixel_out_bus <= '0;
      for (int i = 0; i < PIX_PAD; i++) begin
        pix_pad_r[i] <= '0;
      end
    end else if (adv) begin
      px_r <= fifo_data;
      pix_pad_r[0] <= tap[FILT];
      for (int i = 1; i < PIX_PAD; i++) begin
        pix_pad_r[i] <= pix_pad_r[i-1];
      end
      if (system_control_reg_r[SYS_BYP_BIT]) begin
        pixel_out_bus <= px_r;
      end else begin
        pixel_out_bus <= pix_pad_r[PIX_PAD-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // multiply-accumulate array
  // ----------------------------------------------------------------
  // sum chain enters at the third filter and leaves at the first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int f = 0; f < FILT; f++) begin
        for (int s = 0; s < TAPS; s++) begin
          acc_r[f][s] <= '0;
        end
      end
      for (int f = 0; f < FILT - 1; f++) begin
        link_r[f] <= '0;
      end
    end else if (adv) begin
      for (int f = 0; f < FILT; f++) begin
        for (int s = 0; s < TAPS; s++) begin
          if (s == 0 && f == FILT - 1) begin
            acc_r[f][s] <= mac_term(tap[f+1], coef_r[bank_r][f*TAPS + TAPS-1-s],
                                    data_sgn, coef_sgn);
          end else if (s == 0) begin
            acc_r[f][s] <= link_r[f] + mac_term(tap[f+1],
                           coef_r[bank_r][f*TAPS + TAPS-1-s], data_sgn, coef_sgn);
          end else begin
            acc_r[f][s] <= acc_r[f][s-1] + mac_term(tap[f+1],
                           coef_r[bank_r][f*TAPS + TAPS-1-s], data_sgn, coef_sgn);
          end
        end
      end
      for (int f = 0; f < FILT - 1; f++) begin
        link_r[f] <= acc_r[f+1][TAPS-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // cascade path
  // ----------------------------------------------------------------
  // both paths padded, then added into the cascade output
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < MAC_PAD; i++) begin
        mac_pad_r[i] <= '0;
      end
      for (int i = 0; i < CIN_PAD; i++) begin
        cin_pad_r[i] <= '0;
      end
      cascade_out_bus <= '0;
    end else if (adv) begin
      mac_pad_r[0] <= acc_r[0][TAPS-1];
      for (int i = 1; i < MAC_PAD; i++) begin
        mac_pad_r[i] <= mac_pad_r[i-1];
      end
      cin_pad_r[0] <= signed'(cascade_in_bus);
      for (int i = 1; i < CIN_PAD; i++) begin
        cin_pad_r[i] <= cin_pad_r[i-1];
      end
      cascade_out_bus <= AW'(mac_pad_r[MAC_PAD-1] + cin_pad_r[CIN_PAD-1]);
    end
  end

  // marks the cycle after each step, when outputs are new
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample_step <= 1'b0;
    end else begin
      sample_step <= adv;
    end
  end
endmodule // lmac_top
`default_nettype wire

// ==== src/lmac_pkg.sv ====
`default_nettype none
package lmac_pkg;
  // ----------------------------------------------------------------
  // data and coefficient widths
  // ----------------------------------------------------------------
  localparam int DW = 8;
  localparam int CW = 8;
  localparam int AW = 22;
  localparam int TAPS = 7;
  localparam int FILT = 3;
  localparam int NCOEF = 21;
  localparam int DL_MAX = 1120;
  localparam int DLW = 11;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int RA = 8;
  localparam int RD = 16;
  localparam logic [RA-1:0] REG_SYS = 8'h00;
  localparam logic [RA-1:0] REG_ARR = 8'h01;
  localparam logic [RA-1:0] REG_LEN0 = 8'h02;
  localparam logic [RA-1:0] REG_STAT = 8'h05;
  localparam logic [1:0] COEF_AREA = 2'h1;
  localparam int COEF_BANK_BIT = 5;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SYS_SWAP_BIT = 0;
  localparam int SYS_BYP_BIT = 1;
  localparam int ARR_BANK_BIT = 0;
  localparam int ARR_DSGN_BIT = 1;
  localparam int ARR_CSGN_BIT = 2;
  localparam int STAT_BANK_BIT = 0;
  localparam int STAT_EMPTY_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam logic [1:0] SYS_RST = 2'h0;
  localparam logic [2:0] ARR_RST = 3'h0;
  localparam logic [DLW-1:0] LEN_RST = 11'h000;

  // ----------------------------------------------------------------
  // pipeline padding, in sample steps
  // ----------------------------------------------------------------
  localparam int PIX_PAD = 3;
  localparam int MAC_PAD = 22;
  localparam int CIN_PAD = 5;
endpackage
`default_nettype wire

// ==== src/lmac_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmac_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];

  // occupancy
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt < (PW+1)'(DEPTH));
    end
  end

  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule // lmac_fifo
`default_nettype wire

// ==== src/lmac_delay.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmac_delay #(
  parameter int W = 8,
  parameter int DEPTH = 1120,
  parameter int LW = 11
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // step and length
  input wire logic en,
  input wire logic [LW-1:0] len,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [LW-1:0] wp_r;
  logic [LW-1:0] len_c;
  logic [LW-1:0] rd_idx;

  // length above the ring size is held at the ring size
  assign len_c = (len > LW'(DEPTH)) ? LW'(DEPTH) : len;
  assign rd_idx = (wp_r >= len_c) ? (wp_r - len_c) : LW'(wp_r + LW'(DEPTH) - len_c);
  // zero length passes straight through
  assign dout = (len_c == '0) ? din : mem[rd_idx];

  // ring write pointer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp_r <= '0;
    end else if (en) begin
      wp_r <= (wp_r == LW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
  end

  // ring storage
  always_ff @(posedge sys_clk) begin
    if (en) begin
      mem[wp_r] <= din;
    end
  end
endmodule // lmac_delay
`default_nettype wire

// ==== bench/lmac_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmac_top_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [lmac_pkg::RA-1:0] reg_addr,
  input wire logic [lmac_pkg::RD-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lmac_pkg::RD-1:0] reg_rdata,
  // stream side
  input wire logic array_hold,
  input wire logic [lmac_pkg::DW-1:0] pixel_out_bus,
  input wire logic [lmac_pkg::AW-1:0] cascade_out_bus,
  input wire logic sample_step
);
  import lmac_pkg::*;
  logic [1:0] sys_r;
  logic [2:0] arr_r;
  logic [DLW-1:0] len_r;
  logic swp_r;
  // ----------------------------------------------------------------
  // shadows of host writes
  // ----------------------------------------------------------------
  // copy of what the host wrote
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sys_r <= SYS_RST;
      arr_r <= ARR_RST;
      len_r <= LEN_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_SYS) sys_r <= reg_wdata[1:0];
      if (reg_addr == REG_ARR) arr_r <= reg_wdata[2:0];
      if (reg_addr == REG_LEN0) len_r <= reg_wdata[DLW-1:0];
    end
  end
  // set while auto swap may have moved the bank
  always_ff @(posedge sys_clk) begin
    if (!rst_n) swp_r <= 1'b0;
    else if (reg_wr && reg_addr == REG_ARR) swp_r <= sys_r[SYS_SWAP_BIT];
    else if (sys_r[SYS_SWAP_BIT] || (reg_wr && reg_addr == REG_SYS && reg_wdata[0])) swp_r <= 1'b1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_sys; reg_rd && reg_addr == REG_SYS |=> reg_rdata == {14'h0, sys_r}; endproperty
  a_rd_sys: assert property (p_rd_sys)
    else $error("system control readback");
  property p_rd_arr; reg_rd && reg_addr == REG_ARR && !swp_r |=> reg_rdata == {13'h0, arr_r};
  endproperty
  a_rd_arr: assert property (p_rd_arr)
    else $error("array control readback");
  property p_rd_len; reg_rd && reg_addr == REG_LEN0 |=> reg_rdata == {5'h00, len_r}; endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("line length readback");
  property p_rd_stat; reg_rd && reg_addr == REG_STAT && !swp_r |=> reg_rdata[0] == arr_r[0];
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("active bank in status");
  property p_unmapped; reg_rd && reg_addr == 8'h06 |=> reg_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_out_hold; !sample_step |-> $stable(pixel_out_bus) && $stable(cascade_out_bus);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("outputs moved without a step");
  property p_hold_stall; array_hold [*2] |-> (!sample_step) [*2]; endproperty
  a_hold_stall: assert property (p_hold_stall)
    else $error("step while array held");
endmodule // lmac_top_chk
bind lmac_top lmac_top_chk chk_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .array_hold, .pixel_out_bus, .cascade_out_bus, .sample_step);
`default_nettype wire

// ==== bench/lmac_pix_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmac_pix_src (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // run control
  input wire logic start,
  input wire logic slow,
  input wire logic [15:0] count,
  // block side
  input wire logic pixel_in_ready,
  output logic pixel_in_valid,
  output logic [lmac_pkg::DW-1:0] pixel_in_bus,
  output logic [lmac_pkg::AW-1:0] cascade_in_bus
);
  import lmac_pkg::*;
  logic [15:0] left_r;
  logic [7:0] idx_r;
  logic take;
  logic [15:0] rem;
  assign take = pixel_in_valid && pixel_in_ready;
  assign rem = start ? count : left_r - {15'h0000, take};
  // words not yet accepted
  always_ff @(posedge sys_clk) begin
    if (!rst_n) left_r <= 16'h0000;
    else left_r <= rem;
  end
  // offer odd words, hold until taken, scramble idle bus
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pixel_in_valid <= 1'b0;
      pixel_in_bus <= 8'h00;
      idx_r <= 8'h00;
    end else if (take || !pixel_in_valid) begin
      if (rem != 16'h0000 && !(slow && take)) begin
        pixel_in_valid <= 1'b1;
        pixel_in_bus <= (idx_r * 8'h4b) | 8'h01;
        idx_r <= idx_r + 8'h01;
      end else begin
        pixel_in_valid <= 1'b0;
        pixel_in_bus <= ~pixel_in_bus;
      end
    end
  end
  // upstream cascade word changes every cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) cascade_in_bus <= 22'h3ffff0;
    else cascade_in_bus <= cascade_in_bus + 22'h00a5a7;
  end
endmodule // lmac_pix_src
`default_nettype wire

// ==== bench/lmac_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module lmac_top_test;
  import lmac_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [RA-1:0] reg_addr = 8'h00;
  logic [RD-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [RD-1:0] reg_rdata;
  logic pixel_in_valid;
  logic pixel_in_ready;
  logic [DW-1:0] pixel_in_bus;
  logic array_hold = 1'b0;
  logic [AW-1:0] cascade_in_bus;
  logic [DW-1:0] pixel_out_bus;
  logic [AW-1:0] cascade_out_bus;
  logic sample_step;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic hold_en = 1'b0;
  logic saw_full = 1'b0;
  logic pm;
  logic [15:0] cnt = 16'h0000;
  logic [1:0] hcnt = 2'h0;
  logic [AW-1:0] cin_prev = 22'h000000;
  logic [AW-1:0] pq[$], sq[$], cq[$], iq[$];
  int bad_count = 0;
  int checked = 0;
  lmac_top dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pixel_in_valid, .pixel_in_ready, .pixel_in_bus, .array_hold, .cascade_in_bus,
    .pixel_out_bus, .cascade_out_bus, .sample_step);
  lmac_pix_src src_u (.sys_clk, .rst_n, .start, .slow, .count(cnt), .pixel_in_ready,
    .pixel_in_valid, .pixel_in_bus, .cascade_in_bus);
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  // stall pattern and capture of pushes and steps
  always @(posedge sys_clk) begin
    hcnt <= hcnt + 2'h1;
    array_hold <= hold_en && (hcnt != 2'h0);
    if (hold_en && !pixel_in_ready) saw_full <= 1'b1;
    if (pixel_in_valid && pixel_in_ready) pq.push_back({14'h0, pixel_in_bus});
    if (sample_step) begin
      sq.push_back({14'h0, pixel_out_bus});
      cq.push_back(cascade_out_bus);
      iq.push_back(cin_prev);
    end
    cin_prev <= cascade_in_bus;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [AW-1:0] exp, input logic [AW-1:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [RA-1:0] a, input logic [RD-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [RA-1:0] a, input logic [RD-1:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk("reg_rdata", {6'h0, exp}, {6'h0, reg_rdata});
  endtask
  task coef(input logic bk, input int i, input logic [7:0] v);
    wr(8'h40 | {2'b00, bk, 5'h00} | 8'(i), {8'h00, v});
  endtask
  function automatic logic [AW-1:0] prod(logic [AW-1:0] d, logic [7:0] c, logic ds, logic cs);
    logic signed [9:0] a;
    logic signed [9:0] b;
    logic signed [AW-1:0] p;
    a = ds ? {{2{d[7]}}, d[7:0]} : {2'b00, d[7:0]};
    b = cs ? {{2{c[7]}}, c} : {2'b00, c};
    p = a * b;
    return p;
  endfunction
  task stream(input logic [15:0] n, input logic sl);
    int t;
    pq.delete();
    sq.delete();
    cq.delete();
    iq.delete();
    @(posedge sys_clk);
    cnt <= n;
    slow <= sl;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    t = 0;
    while (sq.size() < int'(n) && t < 5000) begin
      @(posedge sys_clk);
      t++;
    end
    chk("step_count", {6'h0, n}, AW'(sq.size()));
  endtask
  // lag is a latency in steps, the popping step counted as the first
  task pix_chk(input int lag);
    for (int k = lag - 1; k < sq.size(); k++) chk("pixel_out_bus", pq[k-lag+1], sq[k]);
  endtask
  task cas_chk(input int lag, input logic [7:0] c, input logic ds, input logic cs);
    for (int k = lag - 1; k < cq.size(); k++)
      chk("cascade_out_bus", iq[k-5] + prod(pq[k-lag+1], c, ds, cs), cq[k]);
  endtask
  task lens(input logic [RD-1:0] a, input logic [RD-1:0] b, input logic [RD-1:0] c);
    wr(REG_LEN0, a);
    wr(REG_LEN0 + 8'h01, b);
    wr(REG_LEN0 + 8'h02, c);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(REG_STAT, 16'h0002);
    lens(16'h0460, 16'h0000, 16'h0000);
    rd(REG_LEN0, 16'h0460);
    wr(REG_ARR, 16'h0007);
    rd(REG_ARR, 16'h0007);
    rd(REG_STAT, 16'h0003);
    wr(8'h06, 16'hffff);
    rd(8'h06, 16'h0000);
    wr(REG_ARR, 16'h0000);
    lens(16'h0000, 16'h0000, 16'h0000);
    for (int i = 0; i < 42; i++) coef(i / 21, i % 21, 8'h00);
  endtask
  task t_bypass;
    wr(REG_SYS, 16'h0002);
    stream(16'd30, 1'b0);
    pix_chk(2);
    cas_chk(6, 8'h00, 1'b0, 1'b0);
    wr(REG_SYS, 16'h0000);
  endtask
  task t_lines;
    lens(16'h0001, 16'h0002, 16'h0003);
    coef(1'b0, 20, 8'h01);
    hold_en <= 1'b1;
    stream(16'd60, 1'b0);
    hold_en <= 1'b0;
    chk("fifo_refused", 22'h1, {21'h0, saw_full});
    pix_chk(11);
    cas_chk(53, 8'h01, 1'b0, 1'b0);
    lens(16'h0000, 16'h0000, 16'h0460);
    stream(16'd1200, 1'b0);
    pix_chk(1125);
    cas_chk(1167, 8'h01, 1'b0, 1'b0);
    lens(16'h0000, 16'h0000, 16'h0000);
  endtask
  task t_signs;
    coef(1'b0, 20, 8'hfd);
    for (int s = 0; s < 4; s++) begin
      wr(REG_ARR, 16'(s << 1));
      stream(16'd60, 1'b1);
      cas_chk(47, 8'hfd, s[0], s[1]);
    end
    wr(REG_ARR, 16'h0000);
  endtask
  task t_chain;
    coef(1'b0, 0, 8'h01);
    coef(1'b0, 10, 8'h02);
    coef(1'b0, 20, 8'h03);
    stream(16'd60, 1'b0);
    for (int k = 47; k < cq.size(); k++)
      chk("chain_sum", iq[k-5] + pq[k-24] + 22'h2 * pq[k-35] + 22'h3 * pq[k-46],
          cq[k]);
  endtask
  task t_swap;
    logic hit;
    coef(1'b0, 0, 8'h00);
    coef(1'b0, 10, 8'h00);
    coef(1'b1, 20, 8'h05);
    wr(REG_SYS, 16'h0001);
    stream(16'd60, 1'b0);
    pm = 1'b0;
    for (int k = 47; k < cq.size(); k++) begin
      hit = (cq[k] - iq[k-5] === prod(pq[k-46], 8'h05, 1'b0, 1'b0));
      chk("swap_product", prod(pq[k-46], hit ? 8'h05 : 8'h03, 1'b0, 1'b0),
          cq[k] - iq[k-5]);
      if (k > 47) chk("swap_order", {21'h0, !pm}, {21'h0, hit});
      pm = hit;
    end
    wr(REG_SYS, 16'h0000);
    wr(REG_ARR, 16'h0001);
    rd(REG_STAT, 16'h0003);
    stream(16'd60, 1'b0);
    cas_chk(47, 8'h05, 1'b0, 1'b0);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_bypass;
    t_lines;
    t_signs;
    t_chain;
    t_swap;
    test_done;
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    test_done;
  end
endmodule // lmac_top_test
`default_nettype wire
